// File: verilog/cfg_pins_cfg.svh
// Constants for the configuration pin handshake and pin mux.
// Assumes a 100 MHz clock and the shared pin order below.
`ifndef CFG_PINS_CFG_SVH
`define CFG_PINS_CFG_SVH

// Clock period and least internal initialization time
`define CLK_PERIOD_NS 10
`define INIT_TIME_NS 1000
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 16

// Shared pin positions on the pad vectors
`define NUM_PINS 13
`define PIN_SDA 0
`define PIN_SCL 1
`define PIN_TDO 2
`define PIN_TDI 3
`define PIN_TMS 4
`define PIN_TCK 5
`define PIN_MSEL_ALT 6
`define PIN_QD3 7
`define PIN_QD2 8
`define PIN_QD1 9
`define PIN_QD0 10
`define PIN_MSEL 11
`define PIN_MCLK 12

// Pins used by each configuration mode, by JTAG and as clock inputs
`define USE_SSPI 13'h003C
`define USE_I2C 13'h0003
`define USE_MSPI 13'h1E40
`define USE_MQSPI 13'h1FC0
`define JTAG_MASK 13'h003C
`define CLKIN_MASK 13'h1800

`endif

// File: verilog/cfg_pins_pkg.sv
// Types shared by the configuration pin block and its users.
// Widths follow the constants header.
`include "cfg_pins_cfg.svh"

package cfg_pins_pkg;

  // Sequence of the configuration handshake
  typedef enum logic [2:0] {
    ST_INIT, ST_WAIT_INIT, ST_DETECT, ST_LOAD, ST_WAIT_DONE, ST_USER
  } state_t;

  // Strapped boot choice and detected interface
  typedef enum logic [1:0] {BOOT_SLAVE, BOOT_MSPI, BOOT_MQSPI} boot_t;
  typedef enum logic [2:0] {
    MODE_NONE, MODE_SSPI, MODE_I2C, MODE_MSPI, MODE_MQSPI
  } cfg_mode_t;

  // Output drive of the shared pins
  typedef struct packed {
    logic [`NUM_PINS-1:0] o;
    logic [`NUM_PINS-1:0] oe;
  } pad_drive_t;

  // Loader engine drive toward the pins
  typedef struct packed {
    logic mclk;
    logic master_select_n;
    logic [3:0] mdo;
    logic [3:0] mdoe;
    logic slave_serial_out;
    logic slave_serial_out_oe;
    logic sda_low;
  } eng_drive_t;

  // Pin levels returned to the loader engine
  typedef struct packed {
    logic [3:0] mdi;
    logic sclk;
    logic slave_select_n;
    logic slave_serial_in;
    logic sda;
    logic scl;
  } eng_sense_t;

endpackage

// File: verilog/config_pin_handshake_and_mux.sv
// Configuration handshake and shared pin mux of the device.
// Assumes pad inputs synchronous to clk_i; open-drain wiring is external.
//
// Overview of operation
// - Low reconfig request starts new configuration
// - Init indicator pulled low when sequence starts
// - Release init indicator, then download may begin
// - Never download while init line reads low; only the start waits for it, ST_LOAD ignores init
// - Done indicator held low throughout configuration
// - Release done indicator when configuration finishes
// - Delay wake-up while done line held low
// - Detect slave SPI or I2C at activation
// - Unused shared pins stay tri-stated during configuration
// - After configuration pins become GPIO or function
// - Slave SPI: clock, select, input in; output out
// - Master SPI: drive clock, select, output; sample input
// - Quad SPI: four bidirectional data lines
// - I2C pins carry SDA/SCL, user later
// - JTAG enable high gives pins to JTAG
// - JTAG enable low: GPIO or bitstream function
// - Bitstream selects GPIO or function elsewhere
// - Master select/clock pins become primary clock inputs
`timescale 1ns/1ps
`include "cfg_pins_cfg.svh"

module config_pin_handshake_and_mux
  import cfg_pins_pkg::*;
#(
  parameter int INIT_CYCLES = `INIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Handshake pins
  input wire logic reconfig_request_n_i,
  input wire logic init_phase_indicator_n_i,
  output logic init_phase_indicator_n_o,
  output logic init_phase_indicator_n_oe_o,
  input wire logic cfg_done_n_i,
  output logic cfg_done_n_o,
  output logic cfg_done_n_oe_o,
  // Shared pads
  input wire logic [`NUM_PINS-1:0] pad_i,
  output pad_drive_t pad_o,
  // Loader engine
  input wire boot_t boot_mode_i,
  input wire eng_drive_t eng_drive_i,
  input wire logic load_done_i,
  output eng_sense_t eng_sense_o,
  output logic download_go_o,
  output cfg_mode_t cfg_mode_o,
  // User side after wake-up
  input wire logic jtag_en_i,
  input wire logic [`NUM_PINS-1:0] func_sel_i,
  input wire pad_drive_t gpio_drive_i,
  input wire pad_drive_t func_drive_i,
  input wire logic jtag_tdo_i,
  input wire logic jtag_tdo_oe_i,
  output logic [`NUM_PINS-1:0] user_in_o,
  output logic [2:0] jtag_in_o,
  output logic top_primary_clock_in_a_o,
  output logic top_primary_clock_in_b_o,
  output logic user_mode_o
);

  // Mask of pins the given configuration mode uses
  function automatic logic [`NUM_PINS-1:0] used_mask(input cfg_mode_t m);
    case (m)
      MODE_SSPI: used_mask = `USE_SSPI;
      MODE_I2C: used_mask = `USE_I2C;
      MODE_MSPI: used_mask = `USE_MSPI;
      MODE_MQSPI: used_mask = `USE_MQSPI;
      default: used_mask = '0;
    endcase
  endfunction

  // Configuration-time drive for a mode; bits of other pins are masked later
  function automatic pad_drive_t cfg_drive(input cfg_mode_t m,
                                           input eng_drive_t e);
    pad_drive_t d;
    d = '0;
    d.o[`PIN_MCLK] = e.mclk;
    d.oe[`PIN_MCLK] = 1'h1;
    d.o[`PIN_MSEL] = e.master_select_n;
    d.oe[`PIN_MSEL] = 1'h1;
    d.o[`PIN_MSEL_ALT] = e.master_select_n;
    d.oe[`PIN_MSEL_ALT] = 1'h1;
    d.o[`PIN_QD0] = e.mdo[0];
    d.oe[`PIN_QD0] = (m == MODE_MQSPI) ? e.mdoe[0] : 1'h1;
    d.o[`PIN_QD1] = e.mdo[1];
    d.oe[`PIN_QD1] = (m == MODE_MQSPI) & e.mdoe[1];
    d.o[`PIN_QD2] = e.mdo[2];
    d.oe[`PIN_QD2] = e.mdoe[2];
    d.o[`PIN_QD3] = e.mdo[3];
    d.oe[`PIN_QD3] = e.mdoe[3];
    d.o[`PIN_TDO] = e.slave_serial_out;
    d.oe[`PIN_TDO] = e.slave_serial_out_oe;
    d.oe[`PIN_SDA] = e.sda_low;
    d.oe[`PIN_TMS] = 1'h0;
    cfg_drive = d;
  endfunction

  state_t state;
  state_t next_state;
  cfg_mode_t mode;
  cfg_mode_t next_mode;
  logic [`CNT_W-1:0] cnt;
  logic [2:0] sync1;
  logic [2:0] sync2;

  // Two-flop synchronisers for request, init and done levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
    end else begin
      sync1 <= {reconfig_request_n_i, init_phase_indicator_n_i, cfg_done_n_i};
      sync2 <= sync1;
    end
  end

  wire req_s = sync2[2];
  wire init_s = sync2[1];
  wire done_s = sync2[0];

  // Slave activation: select low means SPI, SDA low with SCL high means I2C
  wire sspi_seen = !pad_i[`PIN_TMS];
  wire i2c_seen = !pad_i[`PIN_SDA] && pad_i[`PIN_SCL];
  wire boot_master = (boot_mode_i == BOOT_MSPI) || (boot_mode_i == BOOT_MQSPI);
  wire cfg_mode_t master_mode = (boot_mode_i == BOOT_MQSPI) ? MODE_MQSPI : MODE_MSPI;

  // Next state; a low request overrides every state
  always_comb begin
    next_state = state;
    next_mode = mode;
    if (!req_s) begin
      next_state = ST_INIT;
      next_mode = MODE_NONE;
    end else begin
      case (state)
        ST_INIT: if (cnt == '0) next_state = ST_WAIT_INIT;
        ST_WAIT_INIT: begin
          if (init_s) begin
            next_state = boot_master ? ST_LOAD : ST_DETECT;
            next_mode = boot_master ? master_mode : MODE_NONE;
          end
        end
        ST_DETECT: begin
          if (sspi_seen) begin
            next_state = ST_LOAD;
            next_mode = MODE_SSPI;
          end else if (i2c_seen) begin
            next_state = ST_LOAD;
            next_mode = MODE_I2C;
          end
        end
        ST_LOAD: if (load_done_i) next_state = ST_WAIT_DONE;
        ST_WAIT_DONE: if (done_s) next_state = ST_USER;
        ST_USER: next_state = ST_USER;
        default: next_state = ST_INIT;
      endcase
    end
  end

  // Sequence registers; init timer reloads while request is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_INIT;
      mode <= MODE_NONE;
      cnt <= `CNT_W'(INIT_CYCLES - 1);
    end else begin
      state <= next_state;
      mode <= next_mode;
      if (state != ST_INIT || !req_s) cnt <= `CNT_W'(INIT_CYCLES - 1);
      else if (cnt != '0) cnt <= cnt - `CNT_W'(1);
    end
  end

  // Open-drain handshake drives; both pull low only
  wire in_cfg = (state != ST_USER);
  assign init_phase_indicator_n_o = 1'b0;
  assign init_phase_indicator_n_oe_o = (state == ST_INIT);
  assign cfg_done_n_o = 1'b0;
  assign cfg_done_n_oe_o = (state != ST_USER) && (state != ST_WAIT_DONE);
  assign download_go_o = (state == ST_LOAD);
  assign user_mode_o = (state == ST_USER);
  assign cfg_mode_o = mode;

  // Configuration drive with unused pins forced to tri-state
  wire pad_drive_t cfg_d = cfg_drive(mode, eng_drive_i);
  wire [`NUM_PINS-1:0] cfg_oe = cfg_d.oe & used_mask(mode);

  // User drive: bitstream picks function or GPIO; JTAG overrides its pins
  wire [`NUM_PINS-1:0] jtag_own = jtag_en_i ? `JTAG_MASK : '0;
  wire [`NUM_PINS-1:0] fsel = func_sel_i & ~jtag_own;
  wire [`NUM_PINS-1:0] clk_in = fsel & `CLKIN_MASK;
  wire [`NUM_PINS-1:0] usr_o = (fsel & func_drive_i.o) | (~fsel & gpio_drive_i.o);
  wire [`NUM_PINS-1:0] usr_oe0 = (fsel & func_drive_i.oe) | (~fsel & gpio_drive_i.oe);
  wire [`NUM_PINS-1:0] usr_oe = usr_oe0 & ~jtag_own & ~clk_in;
  wire [`NUM_PINS-1:0] tdo_bit = `NUM_PINS'(1) << `PIN_TDO;
  // TDO data only reaches the pin while JTAG owns it; else it would corrupt user drive
  wire [`NUM_PINS-1:0] jt_o = (jtag_en_i && jtag_tdo_i) ? tdo_bit : '0;
  wire [`NUM_PINS-1:0] jt_oe = (jtag_en_i && jtag_tdo_oe_i) ? tdo_bit : '0;

  // Registered pad drive; user selection only after wake-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o <= '0;
    end else if (in_cfg) begin
      pad_o.o <= cfg_d.o;
      pad_o.oe <= cfg_oe;
    end else begin
      pad_o.o <= (usr_o & ~jtag_own) | jt_o;
      pad_o.oe <= usr_oe | jt_oe;
    end
  end

  // Registered pin levels toward engine and user logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eng_sense_o <= '0;
      user_in_o <= '0;
      jtag_in_o <= '0;
    end else begin
      eng_sense_o.mdi <= {pad_i[`PIN_QD3], pad_i[`PIN_QD2], pad_i[`PIN_QD1],
                          pad_i[`PIN_QD0]};
      eng_sense_o.sclk <= pad_i[`PIN_TCK];
      eng_sense_o.slave_select_n <= pad_i[`PIN_TMS];
      eng_sense_o.slave_serial_in <= pad_i[`PIN_TDI];
      eng_sense_o.sda <= pad_i[`PIN_SDA];
      eng_sense_o.scl <= pad_i[`PIN_SCL];
      user_in_o <= in_cfg ? '0 : pad_i;
      jtag_in_o <= (in_cfg || !jtag_en_i) ? 3'h0 :
                   {pad_i[`PIN_TCK], pad_i[`PIN_TMS], pad_i[`PIN_TDI]};
    end
  end

  // Primary clock inputs pass straight through; a flop would add skew
  assign top_primary_clock_in_a_o = user_mode_o & clk_in[`PIN_MSEL] & pad_i[`PIN_MSEL];
  assign top_primary_clock_in_b_o = user_mode_o & clk_in[`PIN_MCLK] & pad_i[`PIN_MCLK];

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_req_restart;
    !req_s |=> state == ST_INIT && init_phase_indicator_n_oe_o;
  endproperty
  a_req_restart: assert property (p_req_restart)
    else $error("request low did not restart");

  property p_init_low;
    $fell(req_s) |=> init_phase_indicator_n_oe_o [*3];
  endproperty
  a_init_low: assert property (p_init_low)
    else $error("init indicator not pulled low");

  property p_init_release;
    state == ST_INIT && cnt == '0 && req_s |=> !init_phase_indicator_n_oe_o;
  endproperty
  a_init_release: assert property (p_init_release)
    else $error("init indicator not released");

  property p_hold_init;
    state == ST_WAIT_INIT && !init_s && req_s |=> !download_go_o && state == ST_WAIT_INIT;
  endproperty
  a_hold_init: assert property (p_hold_init)
    else $error("download started with init low");

  property p_done_low;
    state inside {ST_INIT, ST_WAIT_INIT, ST_DETECT, ST_LOAD} |-> cfg_done_n_oe_o;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("done indicator not held low");

  property p_done_rel;
    state == ST_LOAD && load_done_i && req_s |=> !cfg_done_n_oe_o;
  endproperty
  a_done_rel: assert property (p_done_rel)
    else $error("done indicator not released");

  property p_wake_hold;
    state == ST_WAIT_DONE && !done_s && req_s |=> !user_mode_o;
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("woke up while done held low");

  property p_unused_tri;
    in_cfg |=> (pad_o.oe & ~used_mask($past(mode))) == '0;
  endproperty
  a_unused_tri: assert property (p_unused_tri)
    else $error("unused pin driven in configuration");

  property p_jtag_tdo;
    user_mode_o && jtag_en_i && jtag_tdo_oe_i |=>
      pad_o.oe[`PIN_TDO] && pad_o.o[`PIN_TDO] == $past(jtag_tdo_i);
  endproperty
  a_jtag_tdo: assert property (p_jtag_tdo)
    else $error("TDO pin not driven by JTAG");

  property p_sync;
    $rose(init_s) |-> $past(init_phase_indicator_n_i, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("init level not synchronised");

endmodule // config_pin_handshake_and_mux

// File: test/cfg_host_model.sv
// Far-side model: host or flash on the shared pins, pull-ups on both indicators.
// Assumes the device pad drive struct and a weak pull-down on undriven pads.
`timescale 1ns/1ps
`include "cfg_pins_cfg.svh"

module cfg_host_model
  import cfg_pins_pkg::*;
(
  // Device open-drain enables and pad drive
  input wire logic init_oe_i,
  input wire logic done_oe_i,
  input wire pad_drive_t pad_i,
  // Bench commands
  input wire logic hold_init_i,
  input wire logic hold_done_i,
  input wire logic [`NUM_PINS-1:0] host_val_i,
  input wire logic [`NUM_PINS-1:0] host_oe_i,
  // Resolved line levels
  output logic init_line_o,
  output logic done_line_o,
  output logic [`NUM_PINS-1:0] pad_level_o
);
  logic flash_drive;
  logic [`NUM_PINS-1:0] flash_bit;

  // Pull-ups; an outside party may stretch either phase by holding low
  assign init_line_o = ~(init_oe_i | hold_init_i);
  assign done_line_o = ~(done_oe_i | hold_done_i);
  // Flash answers on the master input pin while selected, inverse of output bit
  assign flash_drive = pad_i.oe[11] & ~pad_i.o[11] & ~pad_i.oe[9];
  assign flash_bit = {3'h0, flash_drive & ~pad_i.o[10], 9'h000};
  // Device drive wins; undriven pins settle on the pull-down, never a stale value
  assign pad_level_o = (pad_i.oe & pad_i.o) | (~pad_i.oe & host_oe_i & host_val_i)
                     | flash_bit;
endmodule // cfg_host_model

// File: test/config_pin_handshake_and_mux_tb_top.sv
// Self-checking bench for the configuration handshake and shared pin mux.
// Assumes the far-side model and a shortened init time of four cycles.
`timescale 1ns/1ps
`include "cfg_pins_cfg.svh"

module config_pin_handshake_and_mux_tb_top;
  import cfg_pins_pkg::*;
  logic clk_i = 0, rst_i = 1, req_n = 1, load_done = 0, jtag_en = 0, tdo = 0, tdo_oe = 0;
  logic hold_init = 1, hold_done = 0, init_o, init_oe, done_o, done_oe, go, ca, cb, umode;
  logic init_line, done_line;
  logic [12:0] host_val = 13'h0000, host_oe = 13'h0000, func_sel = 13'h0000, pads, uin;
  logic [2:0] jin;
  boot_t boot = BOOT_MSPI;
  eng_drive_t eng = '0;
  pad_drive_t gpio = '0, func = '0, pad_o;
  eng_sense_t sense;
  cfg_mode_t mode;
  int n_errors = 0, num_checks = 0;

  config_pin_handshake_and_mux #(.INIT_CYCLES(4)) config_pin_handshake_and_mux_i (
    .clk_i(clk_i), .rst_i(rst_i), .reconfig_request_n_i(req_n),
    .init_phase_indicator_n_i(init_line), .init_phase_indicator_n_o(init_o),
    .init_phase_indicator_n_oe_o(init_oe), .cfg_done_n_i(done_line), .cfg_done_n_o(done_o),
    .cfg_done_n_oe_o(done_oe), .pad_i(pads), .pad_o(pad_o), .boot_mode_i(boot),
    .eng_drive_i(eng), .load_done_i(load_done), .eng_sense_o(sense), .download_go_o(go),
    .cfg_mode_o(mode), .jtag_en_i(jtag_en), .func_sel_i(func_sel), .gpio_drive_i(gpio),
    .func_drive_i(func), .jtag_tdo_i(tdo), .jtag_tdo_oe_i(tdo_oe), .user_in_o(uin),
    .jtag_in_o(jin), .top_primary_clock_in_a_o(ca), .top_primary_clock_in_b_o(cb),
    .user_mode_o(umode));

  cfg_host_model cfg_host_model_i (
    .init_oe_i(init_oe), .done_oe_i(done_oe), .pad_i(pad_o), .hold_init_i(hold_init),
    .hold_done_i(hold_done), .host_val_i(host_val), .host_oe_i(host_oe),
    .init_line_o(init_line), .done_line_o(done_line), .pad_level_o(pads));

  // Free-running 100 MHz clock
  always #5 clk_i = ~clk_i;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Request pulse, then wait boundedly for the download window
  task automatic start_cfg(input boot_t b, input logic [12:0] hv, input logic [12:0] hoe);
    boot = b;
    host_val = hv;
    host_oe = hoe;
    eng = '0;
    req_n = 0;
    repeat (4) @(negedge clk_i);
    check(init_oe, 1'b1, "init not pulled");
    check(umode, 1'b0, "still in user mode");
    req_n = 1;
    for (int i = 0; i < 60 && go !== 1'b1; i++) @(negedge clk_i);
  endtask

  // Power-up with init held outside, then master pins
  task automatic t_init_hold;
    repeat (30) @(negedge clk_i);
    check(init_oe, 1'b0, "init not released");
    check(go, 1'b0, "download while init low");
    hold_init = 0;
    for (int i = 0; i < 10 && go !== 1'b1; i++) @(negedge clk_i);
    check(go, 1'b1, "no download");
    check(mode, MODE_MSPI, "mode");
    check(done_oe, 1'b1, "done released early");
    check({init_o, done_o}, 2'h0, "open drain data");
    eng.mclk = 1;
    repeat (4) @(negedge clk_i);
    check(pad_o.oe, 13'h1C40, "master oe");
    check(pad_o.o & pad_o.oe, 13'h1000, "master out");
    check(sense.mdi[1], 1'b1, "master in");
    check(uin, 13'h0000, "user in during cfg");
    $display("test init hold done");
  endtask

  // Done line held outside delays wake-up
  task automatic t_done_hold;
    hold_done = 1;
    load_done = 1;
    @(negedge clk_i);
    load_done = 0;
    repeat (6) @(negedge clk_i);
    check(done_oe, 1'b0, "done not released");
    check(umode, 1'b0, "woke while done low");
    hold_done = 0;
    for (int i = 0; i < 10 && umode !== 1'b1; i++) @(negedge clk_i);
    check(umode, 1'b1, "no wake-up");
    $display("test done hold done");
  endtask

  // User mode: JTAG pins, bitstream choice, clock inputs
  task automatic t_user;
    jtag_en = 1;
    host_val = 13'h0828;
    host_oe = 13'h0838;
    tdo = 1;
    tdo_oe = 1;
    repeat (4) @(negedge clk_i);
    check(jin, 3'h5, "jtag inputs");
    check({pad_o.oe[2], pad_o.o[2]}, 2'h3, "jtag out");
    check(uin[3], 1'b1, "user in");
    jtag_en = 0;
    func_sel = 13'h1804;
    gpio = {13'h1FFF, 13'h1FF8};
    func = {13'h0000, 13'h1FFF};
    repeat (3) @(negedge clk_i);
    check(jin, 3'h0, "jtag off");
    check(pad_o.oe, 13'h07FC, "user oe");
    check(pad_o.o & pad_o.oe, 13'h07F8, "user out");
    check({ca, cb}, 2'h2, "clock inputs");
    $display("test user done");
  endtask

  // Slave detection: select low gives slave SPI, else SDA low SCL high gives I2C
  task automatic t_slave;
    start_cfg(BOOT_SLAVE, 13'h0000, 13'h0010);
    eng.slave_serial_out = 1;
    eng.slave_serial_out_oe = 1;
    repeat (3) @(negedge clk_i);
    check(mode, MODE_SSPI, "sspi mode");
    check(pad_o.oe, 13'h0004, "sspi oe");
    check(pad_o.o[2], 1'b1, "sspi out");
    host_val = 13'h0028;
    host_oe = 13'h0038;
    repeat (2) @(negedge clk_i);
    check({sense.sclk, sense.slave_select_n, sense.slave_serial_in}, 3'h5, "sspi in");
    start_cfg(BOOT_SLAVE, 13'h0012, 13'h0013);
    eng.sda_low = 1;
    repeat (3) @(negedge clk_i);
    check(mode, MODE_I2C, "i2c mode");
    check(pad_o.oe, 13'h0001, "i2c oe");
    check(pad_o.o[0], 1'b0, "sda low");
    check({sense.sda, sense.scl}, 2'h1, "i2c in");
    $display("test slave done");
  endtask

  // Quad lines follow per-line enables
  task automatic t_quad;
    start_cfg(BOOT_MQSPI, 13'h0000, 13'h0000);
    eng.mdo = 4'h5;
    eng.mdoe = 4'hF;
    repeat (3) @(negedge clk_i);
    check(mode, MODE_MQSPI, "quad mode");
    check(pad_o.oe, 13'h1FC0, "quad oe");
    check(pad_o.o & pad_o.oe, 13'h0500, "quad out");
    eng.mdoe = 4'h3;
    repeat (3) @(negedge clk_i);
    check(pad_o.oe, 13'h1E40, "quad half oe");
    $display("test quad done");
  endtask

  // Main sequence
  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 0;
    t_init_hold();
    t_done_hold();
    t_user();
    t_slave();
    t_quad();
    tally_and_finish();
  end

  // Watchdog far beyond the roughly 130 cycles the tests take
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
endmodule // config_pin_handshake_and_mux_tb_top
